// >>> tdm_pkg.sv
// Shared constants and types of the ten-channel transfer engine
package tdm_pkg;
  localparam int NCH = 10;
  localparam int CAUSES = 3;
  // Register map: per-channel block, then global registers
  localparam logic [11:0] CH_STRIDE = 12'h010;
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_SRC = 4'h4;
  localparam logic [3:0] OFF_DST = 4'h8;
  localparam logic [3:0] OFF_CNT = 4'hc;
  localparam logic [11:0] REG_STATUS = 12'h100;
  localparam logic [11:0] REG_SWREQ = 12'h104;
  localparam logic [11:0] REG_MASK = 12'h108;
  localparam logic [11:0] GLOBAL_BASE = 12'h100;
  // Control word fields
  localparam int CTL_EN = 0;
  localparam int CTL_SEL = 1;
  localparam int CTL_SIZE = 3;
  localparam int CTL_SDIR = 4;
  localparam int CTL_DDIR = 5;
  localparam int CTL_RING = 6;
  localparam int CTL_W = 7;
  // Reset and special values
  localparam logic [CTL_W-1:0] CTRL_RST = 7'h00;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [7:0] CNT_UNDER = 8'hff;
  localparam logic [31:0] STEP8 = 32'h0000_0001;
  localparam logic [31:0] STEP16 = 32'h0000_0002;
  localparam logic [4:0] RING8_STEP = 5'h01;
  localparam logic [5:0] RING16_STEP = 6'h02;
  localparam logic [1:0] CAUSE_SW = 2'h0;
  localparam logic [1:0] LANE_HI = 2'h2;
  localparam logic [1:0] LANE_LO = 2'h1;
  localparam logic [1:0] LANE_BOTH = 2'h3;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // Machine cycles per transfer cycle at the least
  localparam int XFER_MIN_CYCLES = 3;
  // Engine states, Gray coded along idle, wait, read, write, release
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WAIT = 3'h1,
    ST_RD = 3'h3,
    ST_WR = 3'h2,
    ST_REL = 3'h6
  } tdm_state_e;
endpackage

// >>> tdm_engine.sv
// Ten-channel single-transfer engine with AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
module tdm_engine
  import tdm_pkg::*;
#(
  parameter int NUM_CH = NCH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // AHB-Lite register slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Request causes, three per channel, same clock
  input wire logic [NUM_CH*CAUSES-1:0] reqCause,
  // Shared peripheral bus, borrowed from the CPU
  output logic busReq,
  input wire logic busGnt,
  output logic pbValid,
  output logic pbWrite,
  output logic [31:0] pbAddr,
  output logic [1:0] pbByteEn,
  output logic [15:0] pbWdata,
  input wire logic [15:0] pbRdata,
  input wire logic pbDone,
  // Per-channel events
  output logic [NUM_CH-1:0] xferDone,
  output logic [NUM_CH-1:0] allDone
);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  function automatic logic [1:0] laneOf(input logic a0, input logic size16);
    laneOf = size16 ? LANE_BOTH : (a0 ? LANE_LO : LANE_HI);
  endfunction

  function automatic logic [31:0] alignOf(input logic [31:0] a, input logic size16);
    alignOf = size16 ? {a[31:1], 1'b0} : a;
  endfunction

  function automatic logic [31:0] nextAddr(input logic [31:0] a, input logic inc,
                                           input logic size16, input logic ring);
    logic [4:0] lo5;
    logic [5:0] lo6;
    lo5 = a[4:0] + RING8_STEP;
    lo6 = a[5:0] + RING16_STEP;
    if (!inc) begin
      nextAddr = a;
    end else if (ring && size16) begin
      nextAddr = {a[31:6], lo6};
    end else if (ring) begin
      nextAddr = {a[31:5], lo5};
    end else begin
      nextAddr = a + (size16 ? STEP16 : STEP8);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  logic [CTL_W-1:0] ctrl_r [NUM_CH];
  logic [31:0] src_r [NUM_CH];
  logic [31:0] dst_r [NUM_CH];
  logic [7:0] cnt_r [NUM_CH];
  logic [NUM_CH-1:0] pend_r;
  logic [NUM_CH-1:0] mask_r;
  logic [NUM_CH*CAUSES-1:0] causePrev_r;
  tdm_state_e state_r;
  logic [3:0] curCh_r;
  logic [15:0] hold_r;
  logic [31:0] pbAddr_r;
  logic [1:0] pbByteEn_r;
  logic pbValid_r;
  logic pbWrite_r;
  logic [NUM_CH-1:0] xferDone_r;
  logic [NUM_CH-1:0] allDone_r;

  // AHB data-phase capture
  logic wrPend_r;
  logic [11:0] wrAddr_r;
  logic [31:0] hrdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: zero wait states, reads registered in the address phase

  logic addrPh;
  logic [3:0] rdCh;
  logic [3:0] wrCh;
  logic wrIsCh;
  logic [31:0] rdMux;
  logic [NUM_CH-1:0] swReq;

  assign addrPh = hsel && hready && htrans == HTRANS_NONSEQ;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign rdCh = haddr[7:4];
  assign wrCh = wrAddr_r[7:4];
  assign wrIsCh = wrPend_r && wrAddr_r < GLOBAL_BASE && wrCh < 4'(NUM_CH);

  always_comb begin
    rdMux = RD_ZERO;
    if (haddr[11:0] < GLOBAL_BASE) begin
      if (rdCh < 4'(NUM_CH)) begin
        unique case (haddr[3:0])
          OFF_CTRL: rdMux = 32'(ctrl_r[rdCh]);
          OFF_SRC: rdMux = src_r[rdCh];
          OFF_DST: rdMux = dst_r[rdCh];
          OFF_CNT: rdMux = 32'(cnt_r[rdCh]);
          default: rdMux = RD_ZERO;
        endcase
      end
    end else if (haddr[11:0] == REG_STATUS) begin
      rdMux = 32'(pend_r);
    end else if (haddr[11:0] == REG_MASK) begin
      rdMux = 32'(mask_r);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 12'h000;
      hrdata_r <= RD_ZERO;
    end else begin
      wrPend_r <= addrPh && hwrite;
      wrAddr_r <= haddr[11:0];
      if (addrPh && !hwrite) begin
        hrdata_r <= rdMux;
      end
    end
  end

  assign swReq = (wrPend_r && wrAddr_r == REG_SWREQ) ? hwdata[NUM_CH-1:0] : '0;

  always_ff @(posedge mclk) begin
    if (rst) begin
      mask_r <= '0;
    end else if (wrPend_r && wrAddr_r == REG_MASK) begin
      mask_r <= hwdata[NUM_CH-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request latching and arbitration

  logic [NUM_CH-1:0] reqHit;
  logic [3:0] winCh;
  logic anyPend;
  logic wrDone;
  logic rdDone;

  assign rdDone = state_r == ST_RD && pbDone;
  assign wrDone = state_r == ST_WR && pbDone;

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      logic [1:0] sel;
      sel = ctrl_r[i][CTL_SEL +: 2];
      if (sel == CAUSE_SW) begin
        reqHit[i] = ctrl_r[i][CTL_EN] && swReq[i];
      end else begin
        reqHit[i] = ctrl_r[i][CTL_EN] && reqCause[i*CAUSES + int'(sel) - 1]
                    && !causePrev_r[i*CAUSES + int'(sel) - 1];
      end
    end
  end

  always_comb begin
    winCh = 4'h0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (pend_r[i] && ctrl_r[i][CTL_EN]) begin
        winCh = 4'(i);
      end
    end
  end
  // Enables gathered in a process, so a change of any control word re-evaluates
  logic [NUM_CH-1:0] enBits;
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      enBits[i] = ctrl_r[i][CTL_EN];
    end
  end
  assign anyPend = |(pend_r & enBits);

  always_ff @(posedge mclk) begin
    if (rst) begin
      causePrev_r <= '0;
    end else begin
      causePrev_r <= reqCause;
    end
  end

  // pending until served, a new request wins over the clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      pend_r <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (reqHit[i]) begin
          pend_r[i] <= 1'b1;
        end else if (wrDone && curCh_r == 4'(i)) begin
          pend_r[i] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencer

  logic curSize16;
  assign curSize16 = ctrl_r[curCh_r][CTL_SIZE];

  // a fresh pick is made for each transfer cycle
  // bus held from grant to release
  // valid held until the bus acknowledges
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      curCh_r <= 4'h0;
      pbValid_r <= 1'b0;
      pbWrite_r <= 1'b0;
      pbAddr_r <= ADDR_RST;
      pbByteEn_r <= 2'h0;
      hold_r <= 16'h0000;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (anyPend) begin
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (!anyPend) begin
            state_r <= ST_IDLE;
          end else if (busGnt) begin
            state_r <= ST_RD;
            curCh_r <= winCh;
            pbValid_r <= 1'b1;
            pbWrite_r <= 1'b0;
            pbAddr_r <= alignOf(src_r[winCh], ctrl_r[winCh][CTL_SIZE]);
            // byte lane from address bit zero
            pbByteEn_r <= laneOf(src_r[winCh][0], ctrl_r[winCh][CTL_SIZE]);
          end
        end
        ST_RD: begin
          if (pbDone) begin
            // size picks halfword or single byte
            if (curSize16) begin
              hold_r <= pbRdata;
            end else if (src_r[curCh_r][0]) begin
              hold_r <= {pbRdata[7:0], pbRdata[7:0]};
            end else begin
              hold_r <= {pbRdata[15:8], pbRdata[15:8]};
            end
            state_r <= ST_WR;
            pbWrite_r <= 1'b1;
            pbAddr_r <= alignOf(dst_r[curCh_r], curSize16);
            pbByteEn_r <= laneOf(dst_r[curCh_r][0], curSize16);
          end
        end
        ST_WR: begin
          if (pbDone) begin
            state_r <= ST_REL;
            pbValid_r <= 1'b0;
            pbWrite_r <= 1'b0;
          end
        end
        ST_REL: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  assign busReq = state_r == ST_WAIT || state_r == ST_RD || state_r == ST_WR;
  assign pbValid = pbValid_r;
  assign pbWrite = pbWrite_r;
  assign pbAddr = pbAddr_r;
  assign pbByteEn = pbByteEn_r;
  assign pbWdata = hold_r;

  ////////////////////////////////////////////////////////////////////////////
  // Channel registers: software writes and engine updates

  logic curRing;
  logic finish;
  assign curRing = ctrl_r[curCh_r][CTL_RING];
  // ring mode never ends on the count
  assign finish = wrDone && !curRing && cnt_r[curCh_r] == CNT_RST;

  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        ctrl_r[i] <= CTRL_RST;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (wrIsCh && wrCh == 4'(i) && wrAddr_r[3:0] == OFF_CTRL) begin
          ctrl_r[i] <= hwdata[CTL_W-1:0];
        end
        // ring channels only stop by software
        if (finish && curCh_r == 4'(i)) begin
          ctrl_r[i][CTL_EN] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        src_r[i] <= ADDR_RST;
        dst_r[i] <= ADDR_RST;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (wrDone && curCh_r == 4'(i)) begin
          // fixed or stepped by unit size
          // ring wraps on the low bits
          // byte ring keeps upper 27 bits
          // halfword ring keeps upper 26 bits
          src_r[i] <= nextAddr(src_r[i], ctrl_r[i][CTL_SDIR], ctrl_r[i][CTL_SIZE], ctrl_r[i][CTL_RING]);
          dst_r[i] <= nextAddr(dst_r[i], ctrl_r[i][CTL_DDIR], ctrl_r[i][CTL_SIZE], ctrl_r[i][CTL_RING]);
        end else if (wrIsCh && wrCh == 4'(i)) begin
          if (wrAddr_r[3:0] == OFF_SRC) begin
            src_r[i] <= hwdata;
          end
          if (wrAddr_r[3:0] == OFF_DST) begin
            dst_r[i] <= hwdata;
          end
        end
      end
    end
  end

  // Count is protected while enabled, so a running channel cannot have its count corrupted
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        cnt_r[i] <= CNT_RST;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (wrDone && curCh_r == 4'(i)) begin
          cnt_r[i] <= cnt_r[i] - CNT_ONE;
        end else if (wrIsCh && wrCh == 4'(i) && wrAddr_r[3:0] == OFF_CNT && !ctrl_r[i][CTL_EN]) begin
          cnt_r[i] <= hwdata[7:0];
        end
      end
    end
  end

  // Completion pulses
  always_ff @(posedge mclk) begin
    if (rst) begin
      xferDone_r <= '0;
      allDone_r <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        xferDone_r[i] <= wrDone && curCh_r == 4'(i);
        allDone_r[i] <= finish && curCh_r == 4'(i) && !mask_r[i];
      end
    end
  end
  assign xferDone = xferDone_r;
  assign allDone = allDone_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  logic [7:0] curCnt;
  logic [31:0] curSrc;
  logic curEn;
  assign curCnt = cnt_r[curCh_r];
  assign curSrc = src_r[curCh_r];
  assign curEn = ctrl_r[curCh_r][CTL_EN];

  sequence readPhase;
    state_r == ST_RD && !pbWrite_r && pbValid_r;
  endsequence
  sequence writePhase;
    state_r == ST_WR && pbWrite_r && pbValid_r;
  endsequence

  grant_order_a: assert property (@(posedge mclk) disable iff (rst)
    state_r == ST_WAIT && busGnt && anyPend |=> curCh_r == $past(winCh))
    else $error("grant did not go to lowest pending channel");

  bus_owner_a: assert property (@(posedge mclk) disable iff (rst)
    pbValid_r |-> busReq && busGnt)
    else $error("peripheral access without bus ownership");

  read_write_a: assert property (@(posedge mclk) disable iff (rst)
    readPhase ##0 pbDone ##0 curSize16 |=> writePhase ##0 pbWdata == $past(pbRdata))
    else $error("read not followed by write of held data");

  cycle_min_a: assert property (@(posedge mclk) disable iff (rst)
    state_r == ST_WAIT && busGnt && anyPend |=> state_r == ST_RD ##1 state_r != ST_IDLE ##1 state_r != ST_IDLE)
    else $error("transfer cycle shorter than three machine cycles");

  count_step_a: assert property (@(posedge mclk) disable iff (rst)
    wrDone |=> curCnt == $past(curCnt) - CNT_ONE)
    else $error("count did not drop by one");

  addr_step_a: assert property (@(posedge mclk) disable iff (rst)
    wrDone && !curRing && ctrl_r[curCh_r][CTL_SDIR]
    |=> curSrc == $past(curSrc) + (curSize16 ? STEP16 : STEP8))
    else $error("source address step wrong");

  ring_wrap_a: assert property (@(posedge mclk) disable iff (rst)
    wrDone && curRing && !curSize16 && ctrl_r[curCh_r][CTL_SDIR] && curSrc[4:0] == 5'h1f
    |=> curSrc == {$past(curSrc[31:5]), 5'h00})
    else $error("byte ring did not wrap to start");

  finish_end_a: assert property (@(posedge mclk) disable iff (rst)
    finish |=> !curEn && curCnt == CNT_UNDER && allDone[curCh_r] == !mask_r[curCh_r])
    else $error("normal completion wrong");

  ring_quiet_a: assert property (@(posedge mclk) disable iff (rst)
    wrDone && curRing |=> allDone == '0 ##1 allDone == '0)
    else $error("ring channel signalled completion");

  count_guard_a: assert property (@(posedge mclk) disable iff (rst)
    wrIsCh && wrAddr_r[3:0] == OFF_CNT && ctrl_r[wrCh][CTL_EN] && !(wrDone && curCh_r == wrCh)
    |=> cnt_r[$past(wrCh)] == $past(cnt_r[wrCh]))
    else $error("count changed by write while enabled");

endmodule
`default_nettype wire

// >>> tdm_bus_model.sv
// Peripheral bus partner: CPU-side grant and byte memory
`timescale 1ns/1ps
`default_nettype none
module tdm_bus_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Delays chosen by the bench
  input wire logic [3:0] gntWait,
  input wire logic [3:0] ackWait,
  // Shared bus
  input wire logic busReq,
  output logic busGnt,
  input wire logic pbValid,
  input wire logic pbWrite,
  input wire logic [31:0] pbAddr,
  input wire logic [1:0] pbByteEn,
  input wire logic [15:0] pbWdata,
  output logic [15:0] pbRdata,
  output logic pbDone
);
  logic [7:0] mem [0:4095];
  logic [3:0] gCnt;
  logic [3:0] aCnt;
  logic [11:0] ev;
  assign ev = {pbAddr[11:1], 1'b0};
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
  end
  ////////////////////////////////////////////////////////////
  // grant held while asked
  always @(posedge mclk) begin
    if (rst || !busReq) begin
      busGnt <= 1'b0;
      gCnt <= 4'h0;
    end else if (gCnt >= gntWait) begin
      busGnt <= 1'b1;
    end else begin
      gCnt <= gCnt + 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////
  // one pulse per access
  // Read data is only good with the pulse, so it toggles otherwise
  always @(posedge mclk) begin
    pbDone <= 1'b0;
    pbRdata <= rst ? 16'h0f0f : ~pbRdata;
    if (rst || !pbValid || pbDone) begin
      aCnt <= 4'h0;
    end else if (aCnt >= ackWait) begin
      pbDone <= 1'b1;
      if (!pbWrite) begin
        pbRdata <= {mem[ev], mem[ev | 12'h001]};
      end
      if (pbWrite && pbByteEn[1]) begin
        mem[ev] <= pbWdata[15:8];
      end
      if (pbWrite && pbByteEn[0]) begin
        mem[ev | 12'h001] <= pbWdata[7:0];
      end
    end else begin
      aCnt <= aCnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// >>> tdm_tb.sv
// Self-checking bench of the transfer engine
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tdm_pkg::*;
  typedef struct packed {
    logic w;
    logic [1:0] be;
    logic [31:0] a;
  } tdm_acc_s;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [29:0] reqCause = 30'h0;
  logic [3:0] gntWait = 4'h0;
  logic [3:0] ackWait = 4'h0;
  logic hreadyout, hresp, busReq, busGnt, pbValid, pbWrite, pbDone;
  logic [31:0] hrdata, pbAddr;
  logic [1:0] pbByteEn;
  logic [15:0] pbWdata, pbRdata;
  logic [9:0] xferDone, allDone;
  tdm_acc_s acc[$];
  int errCount = 0;
  int testsRun = 0;
  int xferCnt = 0;
  int doneCnt[10];
  always #12.5 mclk = ~mclk;
  tdm_engine #(.NUM_CH(NCH)) uut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .reqCause(reqCause), .busReq(busReq), .busGnt(busGnt),
    .pbValid(pbValid), .pbWrite(pbWrite), .pbAddr(pbAddr), .pbByteEn(pbByteEn), .pbWdata(pbWdata),
    .pbRdata(pbRdata), .pbDone(pbDone), .xferDone(xferDone), .allDone(allDone));
  tdm_bus_model pm (.mclk(mclk), .rst(rst), .gntWait(gntWait), .ackWait(ackWait), .busReq(busReq),
    .busGnt(busGnt), .pbValid(pbValid), .pbWrite(pbWrite), .pbAddr(pbAddr), .pbByteEn(pbByteEn),
    .pbWdata(pbWdata), .pbRdata(pbRdata), .pbDone(pbDone));
  ////////////////////////////////////////////////////////////
  // Access log and event counts
  always @(posedge mclk) begin
    if (pbValid === 1'b1 && pbDone === 1'b1) begin
      acc.push_back({pbWrite, pbByteEn, pbAddr});
    end
    if (xferDone !== 10'h0) begin
      xferCnt++;
    end
    for (int i = 0; i < 10; i++) begin
      if (allDone[i] === 1'b1) begin
        doneCnt[i]++;
      end
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("Checks run %0d, mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    chk(x, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask
  function automatic logic [31:0] ra(input int ch, input logic [3:0] off);
    return 32'(CH_STRIDE) * 32'(ch) + 32'(off);
  endfunction
  function automatic logic [31:0] ctl(input logic [1:0] sel, input logic sz, sd, dd, rg);
    logic [31:0] c;
    c = 32'h0;
    c[CTL_EN] = 1'b1;
    c[CTL_SEL+:2] = sel;
    c[CTL_SIZE] = sz;
    c[CTL_SDIR] = sd;
    c[CTL_DDIR] = dd;
    c[CTL_RING] = rg;
    return c;
  endfunction
  function automatic logic [7:0] pat(input logic [11:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction
  task automatic cfg(input int ch, input logic [31:0] s, d, n, c);
    wr(ra(ch, OFF_SRC), s);
    wr(ra(ch, OFF_DST), d);
    wr(ra(ch, OFF_CNT), n);
    wr(ra(ch, OFF_CTRL), c);
  endtask
  task automatic waitX(input int n);
    for (int k = 0; k < 400 && xferCnt < n; k++) @(posedge mclk);
    chk(32'(xferCnt), 32'(n));
  endtask
  task automatic chkAcc(input int i, input logic w, input logic [31:0] a, input logic [1:0] be);
    tdm_acc_s e;
    e = (i < acc.size()) ? acc[i] : '0;
    chk({29'h0, e.w, e.be}, {29'h0, w, be});
    chk(e.a, a);
  endtask
  task automatic pulse(input int ch);
    reqCause[ch*CAUSES] <= 1'b1;
    @(posedge mclk);
    reqCause[ch*CAUSES] <= 1'b0;
    @(posedge mclk);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #(25 * 20000);
    errCount++;
    end_sim;
  end
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rdc(ra(0, OFF_CTRL), 32'(CTRL_RST));
    rdc(ra(0, OFF_CNT), 32'(CNT_RST));
    rdc(ra(9, OFF_SRC), ADDR_RST);
    wr(ra(10, OFF_SRC), 32'h0080_1234);
    rdc(ra(10, OFF_SRC), RD_ZERO);
    cfg(0, 32'h0080_0801, 32'h0080_0900, 32'h2, ctl(CAUSE_SW, 0, 1, 1, 0));
    wr(ra(0, OFF_CNT), 32'h55);
    rdc(ra(0, OFF_CNT), 32'h2);
    for (int i = 0; i < 3; i++) begin
      wr(32'(REG_SWREQ), 32'h1);
      waitX(i + 1);
      if (i == 0) rdc(ra(0, OFF_CNT), 32'h1);
    end
    for (int i = 0; i < 3; i++) begin
      chkAcc(2 * i, 0, 32'h0080_0801 + i, i[0] ? LANE_HI : LANE_LO);
      chkAcc(2 * i + 1, 1, 32'h0080_0900 + i, i[0] ? LANE_LO : LANE_HI);
      chk(32'(pm.mem[12'h900 + i]), 32'(pat(12'(12'h801 + i))));
    end
    rdc(ra(0, OFF_CTRL), ctl(CAUSE_SW, 0, 1, 1, 0) & ~32'h1);
    rdc(ra(0, OFF_CNT), 32'(CNT_UNDER));
    rdc(ra(0, OFF_SRC), 32'h0080_0804);
    chk(32'(doneCnt[0]), 32'h1);
    wr(32'(REG_SWREQ), 32'h1);
    rdc(32'(REG_STATUS), 32'h0);
    // Halfword, fixed odd source, slow partner
    acc.delete();
    xferCnt = 0;
    gntWait <= 4'h3;
    ackWait <= 4'h2;
    cfg(1, 32'h0080_0a01, 32'h0080_0b00, 32'h1, ctl(CAUSE_SW, 1, 0, 1, 0));
    for (int i = 0; i < 2; i++) begin
      wr(32'(REG_SWREQ), 32'h2);
      waitX(i + 1);
      chkAcc(2 * i, 0, 32'h0080_0a00, LANE_BOTH);
      chkAcc(2 * i + 1, 1, 32'h0080_0b00 + 2 * i, LANE_BOTH);
    end
    chk({pm.mem[12'hb02], pm.mem[12'hb03]}, {pat(12'ha00), pat(12'ha01)});
    rdc(ra(1, OFF_SRC), 32'h0080_0a01);
    rdc(ra(1, OFF_DST), 32'h0080_0b04);
    // Two channels asked together, one masked
    acc.delete();
    xferCnt = 0;
    gntWait <= 4'ha;
    wr(32'(REG_MASK), 32'h20);
    cfg(5, 32'h0080_0e05, 32'h0080_0f05, 32'h0, ctl(CAUSE_SW, 0, 0, 0, 0));
    cfg(2, 32'h0080_0e02, 32'h0080_0f02, 32'h0, ctl(CAUSE_SW, 0, 0, 0, 0));
    wr(32'(REG_SWREQ), 32'h24);
    rdc(32'(REG_MASK), 32'h20);
    rdc(32'(REG_STATUS), 32'h24);
    waitX(2);
    chkAcc(0, 0, 32'h0080_0e02, LANE_HI);
    chkAcc(2, 0, 32'h0080_0e05, LANE_LO);
    chk(32'(doneCnt[2]), 32'h1);
    chk(32'(doneCnt[5]), 32'h0);
    rdc(32'(REG_STATUS), 32'h0);
    // Ring runs on a cause input, byte then halfword
    gntWait <= 4'h0;
    ackWait <= 4'h0;
    for (int sz = 0; sz < 2; sz++) begin
      acc.delete();
      xferCnt = 0;
      pulse(3 + sz);
      rdc(32'(REG_STATUS), 32'h0);
      cfg(3 + sz, 32'h0080_0c00, 32'h0080_0d00, 32'h0, ctl(2'h1, sz[0], 1, 1, 1));
      for (int k = 0; k < 33; k++) begin
        pulse(3 + sz);
        waitX(k + 1);
      end
      for (int k = 30; k < 33; k++) begin
        logic [31:0] off;
        logic [1:0] be;
        off = 32'((k << sz) & ((32 << sz) - 1));
        be = sz[0] ? LANE_BOTH : (k[0] ? LANE_LO : LANE_HI);
        chkAcc(2 * k, 0, 32'h0080_0c00 + off, be);
        chkAcc(2 * k + 1, 1, 32'h0080_0d00 + off, be);
      end
      wr(ra(3 + sz, OFF_CTRL), 32'h0);
      pulse(3 + sz);
      rdc(32'(REG_STATUS), 32'h0);
      chk(32'(xferCnt), 32'd33);
      chk(32'(doneCnt[3 + sz]), 32'h0);
    end
    end_sim;
  end
endmodule
`default_nettype wire
